/* dv/pslv_ext_master.sv */
// external microprocessor on the slave port pins
`timescale 1ns/1ps
module pslv_ext_master (
    // clock
    input  wire logic       mclk,
    // pins
    input  wire logic [7:0] data_out,
    input  wire logic [7:0] data_oe,
    output logic      [7:0] data_in,
    output logic      [2:0] strb
);
    logic [7:0] drv = 8'h00;
    logic       wr_on = 1'b0;
    initial strb = 3'h7;
    // released bus shows the inverse of the last byte
    assign data_in = (data_oe == 8'hFF) ? data_out : (wr_on ? drv : ~drv);
    task automatic put(input logic [7:0] b);
        drv <= b;
        wr_on <= 1'b1;
        strb <= 3'h1;
        repeat (6) @(posedge mclk);
        strb <= 3'h7;
        @(posedge mclk);
        wr_on <= 1'b0;
        repeat (14) @(posedge mclk);
    endtask
    task automatic get(output logic [7:0] b);
        strb <= 3'h2;
        repeat (6) @(posedge mclk);
        b = data_in;
        strb <= 3'h7;
        repeat (14) @(posedge mclk);
    endtask
endmodule

/* dv/pslv_port_test.sv */
// self-checking bench for the parallel slave port
`timescale 1ns/1ps
module pslv_port_test;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wreq;
    logic        irq;
    logic [7:0]  d_in;
    logic [7:0]  d_out;
    logic [7:0]  d_oe;
    logic [2:0]  strb;
    logic [2:0]  s_out;
    logic [2:0]  s_oe;
    logic [7:0]  q;
    logic [7:0]  b;
    int          errors = 0;
    int          check_count = 0;
    always #12.5 mclk = ~mclk;
    pslv_port u_pslv_port (.MCLK(mclk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .IRQ(irq), .DATA_IN(d_in), .DATA_OUT(d_out), .DATA_OE(d_oe),
        .STRB_IN(strb), .STRB_OUT(s_out), .STRB_OE(s_oe));
    pslv_ext_master u_ext (.mclk(mclk), .data_out(d_out), .data_oe(d_oe), .data_in(d_in),
        .strb(strb));
    task automatic close_out();
        if (errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic av(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        addr <= a;
        wdat <= {24'h0, d};
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge mclk);
            n++;
        end while (wreq !== 1'b0 && n < 16);
        chk("waitrequest", 8'h00, {7'h0, wreq});
        if (wreq !== 1'b0) close_out();
        q = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        av(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask
    function automatic logic [7:0] stat(input logic f, o, v, m);
        return {f, o, v, m, 1'b0, pslv_pkg::RST_STRB_DIR};
    endfunction
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        close_out();
    end
    initial begin
        void'($urandom(32'hA0CFE8E3));
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rchk("status", pslv_pkg::IDX_STAT, stat(0, 0, 0, 0));
        rchk("irq flags", pslv_pkg::IDX_IRQF, 8'h00);
        rchk("unmapped", 8'h50, 8'h00);
        b = 8'($urandom);
        av(1'b1, pslv_pkg::IDX_STRB, b);
        chk("strobe out", {5'h00, b[2:0]}, {5'h00, s_out});
        av(1'b1, pslv_pkg::IDX_STAT, 8'h02);
        chk("strobe drive", 8'h05, {5'h00, s_oe});
        av(1'b1, pslv_pkg::IDX_DDIR, b | 8'h01);
        chk("data drive", ~(b | 8'h01), d_oe);
        av(1'b1, pslv_pkg::IDX_STAT, stat(0, 0, 0, 0));
        u_ext.put(8'($urandom));
        rchk("status", pslv_pkg::IDX_STAT, stat(0, 0, 0, 0));
        av(1'b1, pslv_pkg::IDX_ANA, {4'h0, pslv_pkg::PCFG_DIGITAL});
        av(1'b1, pslv_pkg::IDX_IRQE, 8'h80);
        av(1'b1, pslv_pkg::IDX_STAT, stat(0, 0, 0, 1));
        chk("data drive", 8'h00, d_oe);
        chk("strobe drive", 8'h00, {5'h00, s_oe});
        repeat (3) begin
            b = 8'($urandom);
            u_ext.put(b);
            rchk("status", pslv_pkg::IDX_STAT, stat(1, 0, 0, 1));
            rchk("irq flags", pslv_pkg::IDX_IRQF, 8'h80);
            chk("irq", 8'h01, {7'h0, irq});
            rchk("data", pslv_pkg::IDX_DATA, b);
            rchk("status", pslv_pkg::IDX_STAT, stat(0, 0, 0, 1));
            av(1'b1, pslv_pkg::IDX_IRQF, 8'h00);
            chk("irq", 8'h00, {7'h0, irq});
        end
        u_ext.put(8'($urandom));
        u_ext.put(8'($urandom));
        rchk("status", pslv_pkg::IDX_STAT, stat(1, 0, 1, 1));
        av(1'b1, pslv_pkg::IDX_STAT, stat(0, 0, 1, 0));
        rchk("status", pslv_pkg::IDX_STAT, stat(0, 0, 1, 0));
        av(1'b1, pslv_pkg::IDX_STAT, stat(0, 0, 0, 1));
        av(1'b1, pslv_pkg::IDX_IRQF, 8'h00);
        b = 8'($urandom);
        av(1'b1, pslv_pkg::IDX_DATA, b);
        rchk("status", pslv_pkg::IDX_STAT, stat(0, 1, 0, 1));
        u_ext.get(q);
        chk("pin data", b, q);
        rchk("status", pslv_pkg::IDX_STAT, stat(0, 0, 0, 1));
        rchk("irq flags", pslv_pkg::IDX_IRQF, 8'h80);
        av(1'b1, pslv_pkg::IDX_IRQE, 8'h00);
        chk("irq", 8'h00, {7'h0, irq});
        rchk("events", pslv_pkg::IDX_EVST, 8'h07);
        av(1'b1, pslv_pkg::IDX_EVMSK, 8'h02);
        chk("irq", 8'h01, {7'h0, irq});
        av(1'b1, pslv_pkg::IDX_EVST, 8'h07);
        chk("irq", 8'h00, {7'h0, irq});
        close_out();
    end
endmodule

/* dv/pslv_props.sv */
// checker on the slave port bus and pins
`timescale 1ns/1ps
module pslv_props (
    // clock and reset
    input wire logic        MCLK,
    input wire logic        RST_B,
    // register bus
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    // interrupt and pins
    input wire logic        IRQ,
    input wire logic [2:0]  STRB_IN,
    input wire logic [7:0]  DATA_OE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    wire req = AVS_READ | AVS_WRITE;
    sequence s_ack;
        req && AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence
    sequence s_pins_rd;
        !STRB_IN[0] && !STRB_IN[2];
    endsequence
    property p_wait1; $rose(req) |-> s_ack; endproperty
    property p_idle; !req |-> !AVS_WAITREQUEST; endproperty
    property p_rdhi; AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0; endproperty
    property p_rdstab; $changed(AVS_READDATA) |-> $past(AVS_READ && AVS_WAITREQUEST); endproperty
    property p_oe_rise; $rose(DATA_OE[0]) |-> s_pins_rd; endproperty
    property p_oe_hold; DATA_OE[0] ##0 s_pins_rd |=> DATA_OE[0]; endproperty
    property p_oe_drop; $rose(STRB_IN[0]) |-> ##[1:4] DATA_OE == 8'h00; endproperty
    property p_irq_fall; $fell(IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST); endproperty
    a_wait1: assert property (p_wait1) else $error("wait state missing");
    a_idle: assert property (p_idle) else $error("wait while idle");
    a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
    a_rdstab: assert property (p_rdstab) else $error("read data moved");
    a_oe_rise: assert property (p_oe_rise) else $error("drive without read");
    a_oe_hold: assert property (p_oe_hold) else $error("drive lost in read");
    a_oe_drop: assert property (p_oe_drop) else $error("drive kept");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule
bind pslv_port pslv_props u_pslv_props (.MCLK(MCLK), .RST_B(RST_B), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .IRQ(IRQ), .STRB_IN(STRB_IN), .DATA_OE(DATA_OE));

/* logic/pslv_pkg.sv */
// constants for the parallel slave port block
package pslv_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DATA   = 8'h08;
    localparam logic [7:0] IDX_STRB   = 8'h09;
    localparam logic [7:0] IDX_IRQF   = 8'h0C;
    localparam logic [7:0] IDX_DDIR   = 8'h88;
    localparam logic [7:0] IDX_STAT   = 8'h89;
    localparam logic [7:0] IDX_IRQE   = 8'h8C;
    localparam logic [7:0] IDX_ANA    = 8'h9F;
    localparam logic [7:0] IDX_EVST   = 8'hA0;
    localparam logic [7:0] IDX_EVMSK  = 8'hA1;

    // port_status_direction fields
    localparam int BIT_IBF  = 7;
    localparam int BIT_OBF  = 6;
    localparam int BIT_INPUT_OVERFLOW_FLAG = 5;
    localparam int BIT_MODE = 4;

    // slave flag and enable position in the irq registers
    localparam int BIT_SIRQ = 7;

    // strobe pin positions
    localparam int PIN_RD = 0;
    localparam int PIN_WR = 1;
    localparam int PIN_CS = 2;

    // event status and mask positions
    localparam int EV_WR  = 0;
    localparam int EV_RD  = 1;
    localparam int EV_OVF = 2;

    // implemented bits of the irq and analog setup registers
    localparam logic [7:0] IRQ_MASK = 8'hF7;
    localparam logic [7:0] ANA_MASK = 8'h8F;

    // reset values
    localparam logic [2:0] RST_STRB_DIR = 3'h7;
    localparam logic [7:0] RST_DDIR     = 8'hFF;
    localparam logic [7:0] RST_IRQ      = 8'h00;
    localparam logic [7:0] RST_ANA      = 8'h00;

    // analog config code that leaves the strobe pins digital
    localparam logic [3:0] PCFG_DIGITAL = 4'h6;

    // phase clock positions within one instruction cycle
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q4 = 2'h3;

endpackage

/* logic/pslv_port.sv */
// parallel slave port with avalon register slave
`timescale 1ns/1ps

module pslv_port (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    // avalon slave
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // interrupt
    output logic             IRQ,
    // data pins
    input  wire logic [7:0]  DATA_IN,
    output logic      [7:0]  DATA_OUT,
    output logic      [7:0]  DATA_OE,
    // strobe pins
    input  wire logic [2:0]  STRB_IN,
    output logic      [2:0]  STRB_OUT,
    output logic      [2:0]  STRB_OE
);

    // completion tracker states
    typedef enum logic [1:0] {
        DONE_IDLE,
        DONE_WAIT,
        DONE_ARM
    } pslv_done_t;

    typedef struct packed {
        logic [1:0] phase;
        logic [2:0] strb_s1;
        logic [2:0] strb_s2;
        logic [7:0] data_s1;
        logic [7:0] data_s2;
        logic       wr_act;
        pslv_done_t wr_done;
        logic       rd_act;
        pslv_done_t rd_done;
        logic [7:0] in_latch;
        logic [7:0] out_latch;
        logic       input_full_flag;
        logic       output_full_flag;
        logic       input_overflow_flag;
        logic       mode;
        logic [2:0] strb_dir;
        logic [2:0] strb_lat;
        logic [7:0] data_dir;
        logic [7:0] irq_flags;
        logic [7:0] irq_en;
        logic [7:0] ana;
        logic [2:0] ev;
        logic [2:0] ev_mask;
        logic       ack;
        logic [7:0] rdata;
    } pslv_state_t;

    pslv_state_t s;
    pslv_state_t n;

    logic strobe_on;
    logic wr_now;
    logic rd_now;
    logic q2;
    logic q4;
    logic req;
    logic take;
    logic wen;
    logic obf_set;
    logic [7:0] wd;

    // register read decode
    function automatic logic [7:0] reg_read(
        input pslv_state_t st,
        input logic [7:0]  idx
    );
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            pslv_pkg::IDX_DATA: begin
                if (st.mode) begin
                    v = st.in_latch;
                end else begin
                    v = st.data_s2;
                end
            end
            pslv_pkg::IDX_STRB: begin
                if (st.ana[3:0] == pslv_pkg::PCFG_DIGITAL) begin
                    v = {5'h00, st.strb_s2};
                end
            end
            pslv_pkg::IDX_IRQF: begin
                v = st.irq_flags;
            end
            pslv_pkg::IDX_DDIR: begin
                v = st.data_dir;
            end
            pslv_pkg::IDX_STAT: begin
                v[pslv_pkg::BIT_IBF]  = st.input_full_flag;
                v[pslv_pkg::BIT_OBF]  = st.output_full_flag;
                v[pslv_pkg::BIT_INPUT_OVERFLOW_FLAG] = st.input_overflow_flag;
                v[pslv_pkg::BIT_MODE] = st.mode;
                v[2:0]                = st.strb_dir;
            end
            pslv_pkg::IDX_IRQE: begin
                v = st.irq_en;
            end
            pslv_pkg::IDX_ANA: begin
                v = st.ana;
            end
            pslv_pkg::IDX_EVST: begin
                v = {5'h00, st.ev};
            end
            pslv_pkg::IDX_EVMSK: begin
                v = {5'h00, st.ev_mask};
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // completion: wait for strobe end, arm on Q2, fire on Q4
    function automatic pslv_done_t done_next(
        input pslv_done_t cur,
        input logic       ended,
        input logic       at_q2,
        input logic       at_q4
    );
        pslv_done_t nx;
        nx = cur;
        case (cur)
            DONE_IDLE: begin
                if (ended) begin
                    nx = DONE_WAIT;
                end
            end
            DONE_WAIT: begin
                if (at_q2) begin
                    nx = DONE_ARM;
                end
            end
            DONE_ARM: begin
                if (at_q4) begin
                    nx = DONE_IDLE;
                end
            end
            default: begin
                nx = DONE_IDLE;
            end
        endcase
        return nx;
    endfunction

    // chip select and one strobe both low at the synchronised pins
    function automatic logic strobe_pair_low(
        input logic [2:0] pins,
        input int         which
    );
        return ~pins[pslv_pkg::PIN_CS] & ~pins[which];
    endfunction

    assign strobe_on = s.mode & (&s.strb_dir)
                     & (s.ana[3:0] == pslv_pkg::PCFG_DIGITAL);
    assign wr_now = strobe_on
                  & strobe_pair_low(s.strb_s2, pslv_pkg::PIN_WR);
    assign rd_now = strobe_on
                  & strobe_pair_low(s.strb_s2, pslv_pkg::PIN_RD);
    assign q2   = (s.phase == pslv_pkg::PH_Q2);
    assign q4   = (s.phase == pslv_pkg::PH_Q4);
    assign req  = AVS_READ | AVS_WRITE;
    assign take = req & s.ack;
    assign wen  = take & AVS_WRITE & AVS_BYTEENABLE[0];
    assign wd   = AVS_WRITEDATA[7:0];

    always_comb begin
        n = s;
        obf_set = 1'b0;

        // phase clock and synchronisers
        n.phase   = s.phase + 2'h1;
        n.strb_s1 = STRB_IN;
        n.strb_s2 = s.strb_s1;
        n.data_s1 = DATA_IN;
        n.data_s2 = s.data_s1;

        // bus handshake: one wait cycle, then answer
        if (req & ~s.ack) begin
            n.ack = 1'b1;
            if (AVS_READ) begin
                n.rdata = reg_read(s, AVS_ADDRESS);
            end
        end
        if (take) begin
            n.ack = 1'b0;
        end

        // firmware read side effect
        if (take & AVS_READ & s.mode
            & (AVS_ADDRESS == pslv_pkg::IDX_DATA)) begin
            n.input_full_flag = 1'b0;
        end

        // firmware writes
        if (wen) begin
            case (AVS_ADDRESS)
                pslv_pkg::IDX_DATA: begin
                    n.out_latch = wd;
                    obf_set     = s.mode;
                end
                pslv_pkg::IDX_STRB: begin
                    n.strb_lat = wd[2:0];
                end
                pslv_pkg::IDX_IRQF: begin
                    n.irq_flags = wd & pslv_pkg::IRQ_MASK;
                end
                pslv_pkg::IDX_DDIR: begin
                    n.data_dir = wd;
                end
                pslv_pkg::IDX_STAT: begin
                    n.input_overflow_flag     = wd[pslv_pkg::BIT_INPUT_OVERFLOW_FLAG];
                    n.mode     = wd[pslv_pkg::BIT_MODE];
                    n.strb_dir = wd[2:0];
                end
                pslv_pkg::IDX_IRQE: begin
                    n.irq_en = wd & pslv_pkg::IRQ_MASK;
                end
                pslv_pkg::IDX_ANA: begin
                    n.ana = wd & pslv_pkg::ANA_MASK;
                end
                pslv_pkg::IDX_EVST: begin
                    n.ev = s.ev & ~wd[2:0];
                end
                pslv_pkg::IDX_EVMSK: begin
                    n.ev_mask = wd[2:0];
                end
                default: begin
                end
            endcase
        end

        // external write
        n.wr_act = wr_now;
        if (wr_now) begin
            n.in_latch = s.data_s2;
        end
        if (wr_now & ~s.wr_act & s.input_full_flag) begin
            n.input_overflow_flag = 1'b1;
            n.ev[pslv_pkg::EV_OVF] = 1'b1;
        end
        n.wr_done = done_next(s.wr_done, s.wr_act & ~wr_now, q2, q4);
        // write done flags on the armed Q4
        if ((s.wr_done == DONE_ARM) & q4) begin
            n.input_full_flag    = 1'b1;
            n.irq_flags[pslv_pkg::BIT_SIRQ] = 1'b1;
            n.ev[pslv_pkg::EV_WR] = 1'b1;
        end

        // external read
        n.rd_act = rd_now;
        if (rd_now & ~s.rd_act) begin
            n.output_full_flag = 1'b0;
        end
        n.rd_done = done_next(s.rd_done, s.rd_act & ~rd_now, q2, q4);
        // read done flag on the armed Q4
        if ((s.rd_done == DONE_ARM) & q4) begin
            n.irq_flags[pslv_pkg::BIT_SIRQ] = 1'b1;
            n.ev[pslv_pkg::EV_RD] = 1'b1;
        end

        // firmware data write refills output buffer
        if (obf_set) begin
            n.output_full_flag = 1'b1;
        end

        // general io mode: flags held clear, overflow kept
        if (~n.mode) begin
            n.input_full_flag     = 1'b0;
            n.output_full_flag     = 1'b0;
            n.wr_done = DONE_IDLE;
            n.rd_done = DONE_IDLE;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            s           <= '0;
            s.strb_s1   <= 3'h7;
            s.strb_s2   <= 3'h7;
            s.wr_done   <= DONE_IDLE;
            s.rd_done   <= DONE_IDLE;
            s.ack       <= 1'b0;
            s.rdata     <= 8'h00;
            s.strb_dir  <= pslv_pkg::RST_STRB_DIR;
            s.data_dir  <= pslv_pkg::RST_DDIR;
            s.irq_flags <= pslv_pkg::RST_IRQ;
            s.irq_en    <= pslv_pkg::RST_IRQ;
            s.ana       <= pslv_pkg::RST_ANA;
        end else begin
            s <= n;
        end
    end

    // bus outputs
    assign AVS_WAITREQUEST = req & ~s.ack;
    assign AVS_READDATA    = {24'h000000, s.rdata};

    // interrupt: slave flag with enable, plus masked event status
    assign IRQ = (s.irq_flags[pslv_pkg::BIT_SIRQ]
                  & s.irq_en[pslv_pkg::BIT_SIRQ])
               | (|(s.ev & s.ev_mask));

    // data pins: master steers direction in slave mode
    assign DATA_OUT = s.out_latch;
    assign DATA_OE  = s.mode ? {8{s.rd_act}} : ~s.data_dir;

    // strobe pins never driven in slave mode
    assign STRB_OUT = s.strb_lat;
    assign STRB_OE  = s.mode ? 3'h0 : ~s.strb_dir;

endmodule
